/* File: design/annp_regs.sv */
// next-page transmit and receive registers of the auto-negotiation block
`timescale 1ns/1ps

module annp_regs (
   input  wire logic                              clk_i,
   input  wire logic                              rstn_i,
   // register port
   input  wire annp_pkg::annp_bus_req_s           bus_req_i,
   output logic       [annp_pkg::DATA_W-1:0]      rdata_o,
   // arbitration side, same clock
   input  wire logic                              flp_ack_burst_i,
   input  wire logic                              flp_plain_burst_i,
   input  wire logic                              page_exchanged_i,
   input  wire logic                              an_restart_i,
   input  wire logic                              rx_page_load_i,
   input  wire annp_pkg::annp_page_s              rx_page_i,
   output annp_pkg::annp_page_s                   tx_page_o
);

   //------------------------------------------------------------
   // decode helpers
   //------------------------------------------------------------
   function automatic logic hit(input annp_pkg::annp_bus_req_s r,
                                input logic [annp_pkg::ADDR_W-1:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   // saturates, so a long run of acknowledges keeps the flag set
   function automatic logic [1:0] count_up(input logic [1:0] cnt);
      if (cnt == annp_pkg::ACK_BURST_COUNT) begin
         count_up = cnt;
      end else begin
         count_up = cnt + 2'h1;
      end
   endfunction

   //------------------------------------------------------------
   // transmit state
   //------------------------------------------------------------
   logic                        tx_wr;
   logic                        tx_rd;
   logic [1:0]                  burst_cnt_reg;
   logic [1:0]                  burst_cnt_next;
   logic                        ack_reg;
   logic                        ack_next;
   logic                        more_pages_reg;
   logic                        msg_page_reg;
   logic                        comply_reg;
   logic                        toggle_reg;
   logic                        toggle_next;
   logic [annp_pkg::CODE_W-1:0] code_reg;
   annp_pkg::annp_page_s        tx_page;

   //------------------------------------------------------------
   // receive state
   //------------------------------------------------------------
   logic                        rx_rd;
   logic                        rx_more_pages_reg;
   logic                        rx_ack_reg;
   logic                        rx_msg_page_reg;
   logic                        rx_comply_reg;
   logic                        rx_toggle_reg;
   logic [annp_pkg::CODE_W-1:0] rx_code_reg;
   annp_pkg::annp_page_s        rx_page;

   //------------------------------------------------------------
   // read port state
   //------------------------------------------------------------
   logic [annp_pkg::DATA_W-1:0] rdata_next;

   assign tx_wr = bus_req_i.wr && hit(bus_req_i, annp_pkg::NEXT_PAGE_TRANSMIT_OFS);
   assign tx_rd = bus_req_i.rd && hit(bus_req_i, annp_pkg::NEXT_PAGE_TRANSMIT_OFS);
   assign rx_rd = bus_req_i.rd && hit(bus_req_i, annp_pkg::NEXT_PAGE_RECEIVE_OFS);

   //------------------------------------------------------------
   // software-owned transmit fields
   //------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         more_pages_reg <= annp_pkg::TX_MORE_PAGES_RST;                 // [RULE_01]
      end else if (tx_wr) begin
         more_pages_reg <= bus_req_i.wdata[annp_pkg::MORE_PAGES_BIT];   // [RULE_01]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         msg_page_reg <= annp_pkg::TX_MSG_PAGE_RST;                     // [RULE_06]
      end else if (tx_wr) begin
         msg_page_reg <= bus_req_i.wdata[annp_pkg::MSG_PAGE_BIT];       // [RULE_06]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         comply_reg <= annp_pkg::TX_COMPLY_RST;                         // [RULE_03]
      end else if (tx_wr) begin
         comply_reg <= bus_req_i.wdata[annp_pkg::COMPLY_BIT];           // [RULE_03]
      end
   end

   // code meaning follows the message page selector; stored as written
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         code_reg <= annp_pkg::TX_CODE_NULL_RST;                        // [RULE_05]
      end else if (tx_wr) begin
         code_reg <= bus_req_i.wdata[annp_pkg::CODE_MSB:annp_pkg::CODE_LSB]; // [RULE_05]
      end
   end

   //------------------------------------------------------------
   // acknowledge: three acknowledged bursts in a row
   //------------------------------------------------------------
   // a new page written by software restarts the count; a burst arriving
   // in the same cycle still counts, so no acknowledge is lost
   always_comb begin
      burst_cnt_next = burst_cnt_reg;
      ack_next       = ack_reg;
      if (an_restart_i || flp_plain_burst_i) begin
         burst_cnt_next = 2'h0;                                         // [RULE_02]
         ack_next       = 1'b0;
      end else if (flp_ack_burst_i && tx_wr) begin
         burst_cnt_next = 2'h1;
         ack_next       = 1'b0;
      end else if (flp_ack_burst_i) begin
         burst_cnt_next = count_up(burst_cnt_reg);
         ack_next       = count_up(burst_cnt_reg) == annp_pkg::ACK_BURST_COUNT; // [RULE_02]
      end else if (tx_wr) begin
         burst_cnt_next = 2'h0;
         ack_next       = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         burst_cnt_reg <= 2'h0;
      end else begin
         burst_cnt_reg <= burst_cnt_next;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_reg <= annp_pkg::TX_ACK_RST;                               // [RULE_02]
      end else begin
         ack_reg <= ack_next;                                           // [RULE_02]
      end
   end

   //------------------------------------------------------------
   // toggle tracks the previously exchanged code word
   //------------------------------------------------------------
   // restart wins over a completed exchange in the same cycle
   always_comb begin
      toggle_next = toggle_reg;
      if (an_restart_i) begin
         toggle_next = annp_pkg::TX_TOGGLE_RST;
      end else if (page_exchanged_i) begin
         toggle_next = ~toggle_reg;                                     // [RULE_04]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         toggle_reg <= annp_pkg::TX_TOGGLE_RST;                         // [RULE_04]
      end else begin
         toggle_reg <= toggle_next;
      end
   end

   //------------------------------------------------------------
   // receive page, loaded only by the arbitration side
   //------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_more_pages_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::MORE_PAGES_BIT]; // [RULE_07]
      end else if (rx_page_load_i) begin
         rx_more_pages_reg <= rx_page_i.more_pages_flag;                // [RULE_07]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_ack_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::ACK_BIT];        // [RULE_08]
      end else if (rx_page_load_i) begin
         rx_ack_reg <= rx_page_i.ack;                                   // [RULE_08]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_msg_page_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::MSG_PAGE_BIT]; // [RULE_09]
      end else if (rx_page_load_i) begin
         rx_msg_page_reg <= rx_page_i.message_page_select;              // [RULE_09]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_comply_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::COMPLY_BIT];  // [RULE_10]
      end else if (rx_page_load_i) begin
         rx_comply_reg <= rx_page_i.comply_acknowledge;                 // [RULE_10]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_toggle_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::TOGGLE_BIT];  // [RULE_11]
      end else if (rx_page_load_i) begin
         rx_toggle_reg <= rx_page_i.toggle;                             // [RULE_11]
      end
   end

   // the partner's code word is kept whole; its meaning is up to software
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_code_reg <= annp_pkg::RX_PAGE_RST[annp_pkg::CODE_MSB:annp_pkg::CODE_LSB]; // [RULE_11]
      end else if (rx_page_load_i) begin
         rx_code_reg <= rx_page_i.code;                                 // [RULE_11]
      end
   end

   //------------------------------------------------------------
   // page assembly
   //------------------------------------------------------------
   always_comb begin
      tx_page.more_pages_flag     = more_pages_reg;
      tx_page.ack                 = ack_reg;
      tx_page.message_page_select = msg_page_reg;
      tx_page.comply_acknowledge  = comply_reg;
      tx_page.toggle              = toggle_reg;
      tx_page.code                = code_reg;
   end

   always_comb begin
      rx_page.more_pages_flag     = rx_more_pages_reg;
      rx_page.ack                 = rx_ack_reg;
      rx_page.message_page_select = rx_msg_page_reg;
      rx_page.comply_acknowledge  = rx_comply_reg;
      rx_page.toggle              = rx_toggle_reg;
      rx_page.code                = rx_code_reg;
   end

   //------------------------------------------------------------
   // read port and transmit page output
   //------------------------------------------------------------
   // unmapped addresses read zero; no read side effects, so software
   // may poll either register without disturbing the exchange
   always_comb begin
      rdata_next = 16'h0000;
      if (tx_rd) begin
         rdata_next = tx_page;
      end else if (rx_rd) begin
         rdata_next = rx_page;                                          // [RULE_07] [RULE_08]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= rdata_next;
      end
   end

   // registered copy: the far side sees each field one cycle late
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_page_o <= annp_pkg::RX_PAGE_RST;
      end else begin
         tx_page_o <= tx_page;
      end
   end

endmodule

/* File: pkg/annp_pkg.sv */
// package for the next-page transmit and receive register bank
//------------------------------------------------------------
// Overview of operation
// RULE_01: transmit bit 15 more-pages flag, RW, resets 1
// RULE_02: transmit bit 14 set after three acknowledged bursts
// RULE_03: transmit bit 12 comply acknowledge, RW, resets 0
// RULE_04: transmit bit 11 inverts previous exchanged toggle
// RULE_05: transmit code field RW, resets to null page
// RULE_06: bit 13 selects message or unformatted code
// RULE_07: receive bit 15 shows partner more-pages flag
// RULE_08: receive bit 14 shows partner acknowledge
// RULE_09: receive bit 13 shows partner message page
// RULE_10: receive bit 12 shows partner comply flag
// RULE_11: receive register loads partner page incl. toggle/code
//------------------------------------------------------------
package annp_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   //------------------------------------------------------------
   // register offsets
   //------------------------------------------------------------
   localparam logic [ADDR_W-1:0] NEXT_PAGE_TRANSMIT_OFS = 5'h07;
   localparam logic [ADDR_W-1:0] NEXT_PAGE_RECEIVE_OFS  = 5'h08;

   //------------------------------------------------------------
   // field positions
   //------------------------------------------------------------
   localparam int MORE_PAGES_BIT  = 15;
   localparam int ACK_BIT         = 14;
   localparam int MSG_PAGE_BIT    = 13;
   localparam int COMPLY_BIT      = 12;
   localparam int TOGGLE_BIT      = 11;
   localparam int CODE_MSB        = 10;
   localparam int CODE_LSB        = 0;
   localparam int CODE_W          = CODE_MSB - CODE_LSB + 1;

   //------------------------------------------------------------
   // reset values
   //------------------------------------------------------------
   localparam logic              TX_MORE_PAGES_RST = 1'h1;
   localparam logic              TX_MSG_PAGE_RST   = 1'h1;
   localparam logic              TX_COMPLY_RST     = 1'h0;
   localparam logic              TX_TOGGLE_RST     = 1'h0;
   localparam logic              TX_ACK_RST        = 1'h0;
   localparam logic [CODE_W-1:0] TX_CODE_NULL_RST  = 11'h008;
   localparam logic [DATA_W-1:0] RX_PAGE_RST       = 16'h0000;

   // consecutive acknowledged bursts needed before the ack bit reads 1
   localparam logic [1:0]        ACK_BURST_COUNT   = 2'h3;

   //------------------------------------------------------------
   // page word, as carried in both registers and on the link side
   //------------------------------------------------------------
   typedef struct packed {
      logic              more_pages_flag;
      logic              ack;
      logic              message_page_select;
      logic              comply_acknowledge;
      logic              toggle;
      logic [CODE_W-1:0] code;
   } annp_page_s;

   // register bus request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } annp_bus_req_s;

endpackage

/* File: verif/annp_link_partner.sv */
// behavioural far-side phy: bursts and received pages
`timescale 1ns/1ps

module annp_link_partner (
   input  logic                 clk_i,
   output logic                 ack_o,
   output logic                 plain_o,
   output logic                 load_o,
   output annp_pkg::annp_page_s page_o
);
   initial begin
      ack_o = 1'b0; plain_o = 1'b0; load_o = 1'b0; page_o = '0;
   end
   task automatic bursts(input int n, input logic brk);
      repeat (n) @(posedge clk_i) ack_o <= 1'b1;
      @(posedge clk_i) begin ack_o <= 1'b0; plain_o <= brk; end
      @(posedge clk_i) plain_o <= 1'b0;
   endtask
   // page lines carry garbage once the load strobe drops
   task automatic send_page(input annp_pkg::annp_page_s p);
      @(posedge clk_i) begin load_o <= 1'b1; page_o <= p; end
      @(posedge clk_i) begin load_o <= 1'b0; page_o <= ~p; end
   endtask
endmodule

/* File: verif/annp_regs_properties.sv */
// timing checks on the next-page register ports
`timescale 1ns/1ps

module annp_regs_properties (
   input logic                            clk_i,
   input logic                            rstn_i,
   input annp_pkg::annp_bus_req_s         bus_req_i,
   input logic [annp_pkg::DATA_W-1:0]     rdata_o,
   input logic                            flp_ack_burst_i,
   input logic                            flp_plain_burst_i,
   input logic                            page_exchanged_i,
   input logic                            an_restart_i,
   input logic                            rx_page_load_i,
   input annp_pkg::annp_page_s            rx_page_i,
   input annp_pkg::annp_page_s            tx_page_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   annp_pkg::annp_page_s rx_hold;
   logic                 wr7;
   assign wr7 = bus_req_i.wr && bus_req_i.addr == 5'h07;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) rx_hold <= '0;
      else if (rx_page_load_i) rx_hold <= rx_page_i;
   end
   a_rd_idle: assert property (!$past(bus_req_i.rd) |-> rdata_o == 16'h0000)
      else $error("read data not zero outside read");
   a_rd_tx: assert property ($past(bus_req_i.rd) && $past(bus_req_i.addr) == 5'h07
      |-> rdata_o == tx_page_o) else $error("transmit read differs from page");
   a_rd_rx: assert property ($past(bus_req_i.rd) && $past(bus_req_i.addr) == 5'h08
      |-> rdata_o == $past(rx_hold)) else $error("receive read differs from loaded page");
   a_ack_three: assert property ((flp_ack_burst_i && !flp_plain_burst_i && !an_restart_i
      && !bus_req_i.wr)[*3] |=> ##1 tx_page_o.ack) else $error("ack not set after three");
   a_ack_clear: assert property (flp_plain_burst_i |=> ##1 !tx_page_o.ack)
      else $error("ack kept after plain burst");
   a_wr_ack: assert property (wr7 && !flp_ack_burst_i |=> ##1 !tx_page_o.ack)
      else $error("ack kept after transmit write");
   a_wr_fields: assert property (wr7 |=> ##1
      ((tx_page_o ^ $past(bus_req_i.wdata, 2)) & 16'hB7FF) == 16'h0000)
      else $error("written fields not on transmit page");
   a_tog_flip: assert property (page_exchanged_i && !an_restart_i |=> ##1
      tx_page_o.toggle != $past(tx_page_o.toggle)) else $error("toggle did not flip");
   a_tog_restart: assert property (an_restart_i |=> ##1 !tx_page_o.toggle)
      else $error("toggle not cleared on restart");
   c_ack: cover property (tx_page_o.ack);
   c_flip: cover property (page_exchanged_i);
   c_rx: cover property (bus_req_i.rd && bus_req_i.addr == 5'h08);
endmodule

/* File: verif/tb_top.sv */
// bench for the next-page register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end

module tb_top;
   logic clk = 1'b0, rstn = 1'b0, exch = 1'b0, rst_an = 1'b0, ack, plain, load;
   annp_pkg::annp_bus_req_s req = '0;
   annp_pkg::annp_page_s page, tx;
   logic [15:0] rdata, pg [2] = '{16'hFFFF, 16'h5555};
   int errors = 0, cmp_count = 0, cyc = 0;
   initial forever #12.5 clk = ~clk;
   annp_regs i_annp_regs (.clk_i(clk), .rstn_i(rstn), .bus_req_i(req), .rdata_o(rdata),
      .flp_ack_burst_i(ack), .flp_plain_burst_i(plain), .page_exchanged_i(exch),
      .an_restart_i(rst_an), .rx_page_load_i(load), .rx_page_i(page), .tx_page_o(tx));
   annp_link_partner i_annp_link_partner (.clk_i(clk), .ack_o(ack), .plain_o(plain),
      .load_o(load), .page_o(page));
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk) req <= {2'b10, a, d};
      @(posedge clk) req <= '0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk) req <= {2'b01, a, 16'h0000};
      @(posedge clk) req <= '0;
      #1 `CHK("rdata", e, rdata)
   endtask
   task automatic finish_test;
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin errors++; finish_test(); end
   end
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd(5'h07, 16'hA008);
      rd(5'h08, 16'h0000);
      i_annp_link_partner.bursts(2, 1'b1);
      rd(5'h07, 16'hA008);
      i_annp_link_partner.bursts(3, 1'b0);
      rd(5'h07, 16'hE008);
      `CHK("tx_page", 16'hE008, tx)
      wr(5'h07, 16'hFFFF);
      rd(5'h07, 16'hB7FF);
      wr(5'h07, 16'h0000);
      rd(5'h07, 16'h0000);
      @(posedge clk) exch <= 1'b1;
      @(posedge clk) exch <= 1'b0;
      rd(5'h07, 16'h0800);
      @(posedge clk) rst_an <= 1'b1;
      @(posedge clk) rst_an <= 1'b0;
      rd(5'h07, 16'h0000);
      foreach (pg[i]) begin
         i_annp_link_partner.send_page(pg[i]);
         wr(5'h08, ~pg[i]);
         rd(5'h08, pg[i]);
      end
      rd(5'h1F, 16'h0000);
      finish_test();
   end
endmodule

bind annp_regs annp_regs_properties i_annp_regs_properties (.clk_i(clk_i), .rstn_i(rstn_i),
   .bus_req_i(bus_req_i), .rdata_o(rdata_o), .flp_ack_burst_i(flp_ack_burst_i),
   .flp_plain_burst_i(flp_plain_burst_i), .page_exchanged_i(page_exchanged_i),
   .an_restart_i(an_restart_i), .rx_page_load_i(rx_page_load_i), .rx_page_i(rx_page_i),
   .tx_page_o(tx_page_o));
